// ### rtl/psfc_pkg.sv
package psfc_pkg;

  // Clock rate and timing figures
  localparam int CLK_KHZ = 50000;
  localparam int CYC_PER_US = CLK_KHZ / 1000;
  localparam int TERM_50_MS = 50;
  localparam int TERM_100_MS = 100;
  localparam int TERM_200_MS = 200;
  localparam int TERM_50_CYC = TERM_50_MS * CLK_KHZ;
  localparam int TERM_100_CYC = TERM_100_MS * CLK_KHZ;
  localparam int TERM_200_CYC = TERM_200_MS * CLK_KHZ;
  localparam int POFF_1P5_US = 1500;
  localparam int POFF_12P5_US = 12500;
  localparam int POFF_25_US = 25000;
  localparam int POFF_50_US = 50000;
  localparam int POFF_1P5_CYC = POFF_1P5_US * CYC_PER_US;
  localparam int POFF_12P5_CYC = POFF_12P5_US * CYC_PER_US;
  localparam int POFF_25_CYC = POFF_25_US * CYC_PER_US;
  localparam int POFF_50_CYC = POFF_50_US * CYC_PER_US;
  localparam int GLITCH_US = 8;
  localparam int GLITCH_CYC = GLITCH_US * CYC_PER_US;
  localparam logic [8:0] GLITCH_LIM = 9'(GLITCH_CYC);
  localparam int RAMP_STEP_US = 10;
  localparam logic [9:0] RAMP_LIM = 10'(RAMP_STEP_US * CYC_PER_US - 1);
  localparam logic [23:0] TIMER_MAX = 24'hFFFFFF;

  // Code limits
  localparam logic [7:0] REF_MAX = 8'hFA;
  localparam logic [7:0] OFS_MAX = 8'h7D;
  localparam logic [7:0] DUTY_MIN = 8'h1A;
  localparam logic [7:0] DUTY_MAX = 8'hE6;
  localparam logic [1:0] FIRST_POS = 2'h0;
  localparam logic [1:0] LAST_POS = 2'h3;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PON = 3'b001,
    ST_ON = 3'b010,
    ST_POFF_WAIT = 3'b011,
    ST_POFF_DLY = 3'b100
  } psfc_state_t;

  // Fault and battery responses
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_FORCE = 2'b01,
    ACT_POFF = 2'b10
  } psfc_act_t;

  // Termination period select
  typedef enum logic [1:0] {
    TERM_OFF = 2'b00,
    TERM_50 = 2'b01,
    TERM_100 = 2'b10,
    TERM_200 = 2'b11
  } psfc_term_t;

  // Margin command codes
  typedef enum logic [1:0] {
    MRG_NOM = 2'b00,
    MRG_HIGH = 2'b01,
    MRG_LOW = 2'b10
  } psfc_msel_t;

  // Static configuration
  typedef struct packed {
    logic [3:0] manual;
    logic [3:0][1:0] pos;
    psfc_term_t term_sel;
    logic [1:0] poff_sel;
    logic [3:0][1:0] mon_level;
    logic [3:0] glitch_on;
    psfc_act_t fault_act;
    logic health_en;
    psfc_act_t batt_act;
    logic batt_latch;
    logic [2:0] slew_sel;
    logic [3:0] slew_dis;
    logic [1:0][2:0] tap;
  } psfc_cfg_t;

  // Command strobes, one cycle each
  typedef struct packed {
    logic power_on;
    logic power_off;
    logic force_off;
    logic margin;
    logic [3:0][1:0] margin_sel;
  } psfc_cmd_t;

  // Stored voltage settings
  typedef struct packed {
    logic [3:0][7:0] nom;
    logic [3:0][7:0] high;
    logic [3:0][7:0] low;
  } psfc_mrg_t;

  // Settings toward the analog side
  typedef struct packed {
    logic [3:0][7:0] vset;
    logic [1:0][2:0] tap;
    logic [2:0] slew_sel;
    logic [3:0] slew_en;
    logic [3:0][1:0] mon_level;
  } psfc_ana_t;

endpackage : psfc_pkg

// ### rtl/psfc_glitch.sv
`timescale 1ns/1ns
module psfc_glitch (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Filter setting and raw violation
  input wire logic filter_on,
  input wire logic violation,
  // Qualified fault level
  output logic fault
);
  import psfc_pkg::*;

  logic [8:0] cnt;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Persistence counter, saturates at the filter length
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt <= 9'h000;
    end else if (!violation) begin
      cnt <= 9'h000;
    end else if (cnt != GLITCH_LIM) begin
      cnt <= cnt + 9'h001;
    end
  end

  // Fault only once the violation outlasts the filter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fault <= 1'b0;
    end else begin
      fault <= violation && (!filter_on || cnt == GLITCH_LIM);
    end
  end

  AST_GLITCH_CLEAR: assert property (!violation |=> !fault)
    else $error("fault held without violation");
  AST_GLITCH_LONG: assert property ($rose(fault) && $past(filter_on) |-> $past(cnt) == GLITCH_LIM)
    else $error("fault raised before filter time");

endmodule : psfc_glitch

// ### rtl/psfc_top.sv
`timescale 1ns/1ns
module psfc_top #(
  parameter int TERM_50_CYC = psfc_pkg::TERM_50_CYC,
  parameter int TERM_100_CYC = psfc_pkg::TERM_100_CYC,
  parameter int TERM_200_CYC = psfc_pkg::TERM_200_CYC,
  parameter int POFF_1P5_CYC = psfc_pkg::POFF_1P5_CYC,
  parameter int POFF_12P5_CYC = psfc_pkg::POFF_12P5_CYC,
  parameter int POFF_25_CYC = psfc_pkg::POFF_25_CYC,
  parameter int POFF_50_CYC = psfc_pkg::POFF_50_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration, commands and stored settings
  input wire psfc_pkg::psfc_cfg_t cfg,
  input wire psfc_pkg::psfc_cmd_t cmd,
  input wire psfc_pkg::psfc_mrg_t mrg,
  input wire logic [3:0] chan_enable,
  input wire logic [3:0][7:0] duty_req,
  // Analog comparators, asynchronous
  input wire logic [3:0] out_good,
  input wire logic [3:0] out_over,
  input wire logic [1:0] batt_low_raw,
  // Channel control and settings
  output logic [3:0] chan_on,
  output psfc_pkg::psfc_ana_t ana,
  output logic [3:0][7:0] duty,
  // Status
  output psfc_pkg::psfc_state_t seq_state,
  output logic [1:0] seq_pos,
  output logic unhealthy,
  output logic margin_done
);
  import psfc_pkg::*;

  logic [9:0] sync1;
  logic [9:0] sync2;
  logic [3:0] good;
  logic [3:0] over;
  logic batt_low;
  logic batt_q;
  logic fault_q;
  logic batt_hold;
  logic [3:0] seq_on;
  logic [3:0] mon_active;
  logic [3:0] man_on;
  logic man_kill;
  logic pos_enter;
  logic [3:0] fault_flt;
  logic [3:0] cur_mask;
  logic [23:0] term_cnt;
  logic [23:0] dly_cnt;
  logic [23:0] term_lim;
  logic [23:0] dly_lim;
  logic [9:0] ramp_cnt;
  logic [3:0][1:0] mrg_sel;
  logic [3:0][7:0] tgt;
  logic term_en;
  logic term_run;
  logic term_exp;
  logic dly_done;
  logic poff_busy;
  logic any_fault;
  logic fault_evt;
  logic batt_evt;
  logic auto_restart;
  logic pon_req;
  logic poff_req;
  logic force_req;
  logic ramp_tick;
  logic duty_ok;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Non-manual channels that occupy a given position
  function automatic logic [3:0] in_pos(input logic [1:0] p);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m[i] = !cfg.manual[i] && cfg.pos[i] == p;
    end
    return m;
  endfunction : in_pos

  // Comparator levels cross in through two flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1 <= 10'h000;
      sync2 <= 10'h000;
    end else begin
      sync1 <= {batt_low_raw, out_over, out_good};
      sync2 <= sync1;
    end
  end

  assign good = sync2[3:0];
  assign over = sync2[7:4];
  assign batt_low = |sync2[9:8];
  assign cur_mask = in_pos(seq_pos);
  assign poff_busy = seq_state == ST_POFF_WAIT || seq_state == ST_POFF_DLY;

  // Period selects
  always_comb begin
    case (cfg.term_sel)
      TERM_50: term_lim = 24'(TERM_50_CYC);
      TERM_100: term_lim = 24'(TERM_100_CYC);
      TERM_200: term_lim = 24'(TERM_200_CYC);
      default: term_lim = TIMER_MAX;
    endcase
    case (cfg.poff_sel)
      2'b00: dly_lim = 24'(POFF_1P5_CYC);
      2'b01: dly_lim = 24'(POFF_12P5_CYC);
      2'b10: dly_lim = 24'(POFF_25_CYC);
      default: dly_lim = 24'(POFF_50_CYC);
    endcase
  end

  // One filter per monitored output; only channels already up are watched
  for (genvar i = 0; i < 4; i++) begin : g_mon
    psfc_glitch u_glitch (
      .clock(clock),
      .reset(reset),
      .filter_on(cfg.glitch_on[i]),
      .violation(mon_active[i] && (!good[i] || over[i])),
      .fault(fault_flt[i])
    );
  end

  // Edge detect on battery and output faults
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      batt_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      batt_q <= batt_low;
      fault_q <= any_fault;
    end
  end

  assign any_fault = |fault_flt;
  assign fault_evt = any_fault && !fault_q;
  assign batt_evt = batt_low && !batt_q;

  // Termination timer expiry, only while a position is being worked
  assign term_en = cfg.term_sel != TERM_OFF;
  assign term_run = seq_state == ST_PON || seq_state == ST_POFF_WAIT;
  assign term_exp = term_en && term_run && !pos_enter && term_cnt == term_lim - 24'h1;
  assign dly_done = seq_state == ST_POFF_DLY && dly_cnt == dly_lim - 24'h1;

  // Request sources
  assign auto_restart = batt_hold && !cfg.batt_latch && !batt_low;
  assign pon_req = (cmd.power_on || auto_restart) && !batt_low;
  assign force_req = cmd.force_off || term_exp
    || (fault_evt && cfg.fault_act == ACT_FORCE)
    || (batt_evt && cfg.batt_act == ACT_FORCE);
  assign poff_req = cmd.power_off
    || (fault_evt && cfg.fault_act == ACT_POFF)
    || (batt_evt && cfg.batt_act == ACT_POFF);

  // Battery hold: latched until power-on, or until recovery once idle
  // Waiting for idle keeps a recovery during power-off from losing the restart
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      batt_hold <= 1'b0;
    end else if (batt_evt && cfg.batt_act != ACT_NONE) begin
      batt_hold <= 1'b1;
    end else if (cfg.batt_latch ? cmd.power_on : (!batt_low && seq_state == ST_IDLE)) begin
      batt_hold <= 1'b0;
    end
  end

  // Sequencer; shutdown outranks everything so a hung step cannot block it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seq_state <= ST_IDLE;
      seq_pos <= FIRST_POS;
      seq_on <= 4'h0;
      mon_active <= 4'h0;
      pos_enter <= 1'b0;
    end else begin
      pos_enter <= 1'b0;
      if (force_req) begin
        seq_state <= ST_IDLE;
        seq_on <= 4'h0;
        mon_active <= 4'h0;
      end else if (poff_req && (seq_state == ST_PON || seq_state == ST_ON)) begin
        seq_state <= ST_POFF_WAIT;
        seq_pos <= LAST_POS;
        pos_enter <= 1'b1;
        seq_on <= seq_on & ~in_pos(LAST_POS);
        mon_active <= 4'h0;
      end else begin
        case (seq_state)
          ST_IDLE: begin
            if (pon_req) begin
              seq_state <= ST_PON;
              seq_pos <= FIRST_POS;
              pos_enter <= 1'b1;
              seq_on <= in_pos(FIRST_POS);
            end
          end
          ST_PON: begin
            mon_active <= mon_active | (seq_on & good);
            if ((cur_mask & good) == cur_mask) begin
              if (seq_pos == LAST_POS) begin
                seq_state <= ST_ON;
              end else begin
                seq_pos <= seq_pos + 2'h1;
                pos_enter <= 1'b1;
                seq_on <= seq_on | in_pos(seq_pos + 2'h1);
              end
            end
          end
          ST_ON: begin
            mon_active <= mon_active | (seq_on & good);
          end
          ST_POFF_WAIT: begin
            if ((cur_mask & good) == 4'h0) begin
              if (seq_pos == FIRST_POS) begin
                seq_state <= ST_IDLE;
              end else begin
                seq_pos <= seq_pos - 2'h1;
                seq_state <= ST_POFF_DLY;
              end
            end
          end
          ST_POFF_DLY: begin
            if (dly_done) begin
              seq_state <= ST_POFF_WAIT;
              pos_enter <= 1'b1;
              seq_on <= seq_on & ~cur_mask;
            end
          end
          default: begin
            seq_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Termination counter, cleared on every position entry
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      term_cnt <= 24'h000000;
    end else if (pos_enter || !term_run) begin
      term_cnt <= 24'h000000;
    end else if (term_cnt != TIMER_MAX) begin
      term_cnt <= term_cnt + 24'h000001;
    end
  end

  // Power-off step delay counter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dly_cnt <= 24'h000000;
    end else if (seq_state != ST_POFF_DLY) begin
      dly_cnt <= 24'h000000;
    end else begin
      dly_cnt <= dly_cnt + 24'h000001;
    end
  end

  // Manual kill: shutdown command wins over a power-on in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      man_kill <= 1'b0;
    end else if (cmd.force_off) begin
      man_kill <= 1'b1;
    end else if (cmd.power_on) begin
      man_kill <= 1'b0;
    end
  end

  // Manual channels follow their enable, frozen during power-off; faults ignored
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      man_on <= 4'h0;
    end else if (!poff_busy) begin
      man_on <= chan_enable & {4{!man_kill}};
    end
  end

  // Channel enables to the regulators
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      chan_on <= 4'h0;
    end else begin
      chan_on <= (seq_on & ~cfg.manual) | (man_on & cfg.manual);
    end
  end

  // Health flag: a new fault wins over a clearing power-on
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      unhealthy <= 1'b0;
    end else if (fault_evt && cfg.health_en) begin
      unhealthy <= 1'b1;
    end else if (cmd.power_on) begin
      unhealthy <= 1'b0;
    end
  end

  // Margin selection captured per command
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mrg_sel <= {4{MRG_NOM}};
    end else if (cmd.margin) begin
      mrg_sel <= cmd.margin_sel;
    end
  end

  // Target codes, clamped to each reference range
  always_comb begin
    logic [7:0] v;
    logic [7:0] lim;
    v = 8'h00;
    lim = 8'h00;
    for (int i = 0; i < 4; i++) begin
      case (mrg_sel[i])
        MRG_HIGH: v = mrg.high[i];
        MRG_LOW: v = mrg.low[i];
        default: v = mrg.nom[i];
      endcase
      lim = (i == 0) ? OFS_MAX : REF_MAX;
      tgt[i] = (v > lim) ? lim : v;
    end
  end

  // Ramp step timer; slow steps keep margining from jumping the output
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ramp_cnt <= 10'h000;
    end else if (ramp_tick) begin
      ramp_cnt <= 10'h000;
    end else begin
      ramp_cnt <= ramp_cnt + 10'h001;
    end
  end

  assign ramp_tick = ramp_cnt == RAMP_LIM;

  // Analog settings; no soft-start while powering off
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ana <= '0;
    end else begin
      ana.tap <= cfg.tap;
      ana.slew_sel <= cfg.slew_sel;
      ana.slew_en <= ~cfg.slew_dis & {4{!poff_busy}};
      ana.mon_level <= cfg.mon_level;
      for (int i = 0; i < 4; i++) begin
        if (ramp_tick && ana.vset[i] < tgt[i]) begin
          ana.vset[i] <= ana.vset[i] + 8'h01;
        end else if (ramp_tick && ana.vset[i] > tgt[i]) begin
          ana.vset[i] <= ana.vset[i] - 8'h01;
        end
      end
    end
  end

  // Margin status: every setting sits at its target
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      margin_done <= 1'b0;
    end else begin
      margin_done <= ana.vset == tgt && !cmd.margin;
    end
  end

  // Duty clamp
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      duty <= {4{DUTY_MIN}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (duty_req[i] < DUTY_MIN) begin
          duty[i] <= DUTY_MIN;
        end else if (duty_req[i] > DUTY_MAX) begin
          duty[i] <= DUTY_MAX;
        end else begin
          duty[i] <= duty_req[i];
        end
      end
    end
  end

  // Checker helper: every duty inside the window
  always_comb begin
    duty_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (duty[i] < DUTY_MIN || duty[i] > DUTY_MAX) begin
        duty_ok = 1'b0;
      end
    end
  end

  AST_FORCE_IDLE: assert property (force_req |=> seq_state == ST_IDLE && seq_on == 4'h0
    ##1 chan_on == ($past(man_on) & $past(cfg.manual)))
    else $error("shutdown did not clear channels");
  AST_SEQ_NO_MANUAL: assert property ((seq_on & cfg.manual) == 4'h0 || $changed(cfg.manual))
    else $error("sequencer drove a manual channel");
  AST_MANUAL_FAULT: assert property (fault_evt && !cmd.force_off && !poff_busy |=> man_on == $past(chan_enable & {4{!man_kill}}))
    else $error("manual channel dropped on fault");
  AST_TERM_RESTART: assert property (pos_enter |=> term_cnt == 24'h000000)
    else $error("termination timer not restarted");
  AST_TERM_OFF: assert property (cfg.term_sel == TERM_OFF |-> !term_exp)
    else $error("disabled timer expired");
  AST_POFF_ENTRY: assert property (poff_req && !force_req && seq_state == ST_ON |=> seq_state == ST_POFF_WAIT && seq_pos == LAST_POS)
    else $error("power-off did not start at last position");
  AST_POFF_FREEZE: assert property (poff_busy |=> $stable(man_on))
    else $error("enable acted during power-off");
  AST_POFF_STEP: assert property (dly_done && !force_req |=> seq_state == ST_POFF_WAIT && pos_enter)
    else $error("power-off delay did not step");
  AST_TERM_POFF: assert property (term_exp |=> seq_state == ST_IDLE)
    else $error("timer expiry did not shut down");
  AST_HEALTH: assert property (fault_evt && cfg.health_en |=> unhealthy)
    else $error("health flag not raised");
  AST_DUTY: assert property (duty_ok)
    else $error("duty outside window");
  AST_PON_ADV: assert property (seq_state == ST_PON && (cur_mask & good) != cur_mask && !force_req && !poff_req |=> $stable(seq_pos))
    else $error("position advanced early");

endmodule : psfc_top

// ### test/psfc_analog_model.sv
`timescale 1ns/1ns
module psfc_analog_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Channel enables and fault injection
  input wire logic [3:0] chan_on,
  input wire logic [3:0] stuck_low,
  input wire logic [3:0] over_inj,
  // Comparator outputs
  output logic [3:0] out_good,
  output logic [3:0] out_over
);
  logic [3:0] d1;
  logic [3:0] d2;
  // Output reaches good a few cycles after enable; a stuck channel never does
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      d1 <= 4'h0;
      d2 <= 4'h0;
      out_good <= 4'h0;
    end else begin
      d1 <= chan_on;
      d2 <= d1;
      out_good <= d2 & chan_on & ~stuck_low;
    end
  end
  // Overvoltage only shows on a live output
  assign out_over = over_inj & out_good;
endmodule : psfc_analog_model

// ### test/power_sequencer_fault_control_bench.sv
`timescale 1ns/1ns
module power_sequencer_fault_control_bench;
  import psfc_pkg::*;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("FAIL %0t %h %h", $time, (a), (b)); end end
  // Bench signals
  logic clock, reset;
  psfc_cfg_t cfg;
  psfc_cmd_t cmd;
  psfc_mrg_t mrg;
  logic [3:0] chan_enable, out_good, out_over, chan_on, stuck_low, over_inj;
  logic [3:0][7:0] duty_req, duty;
  logic [1:0] batt_low_raw, seq_pos;
  psfc_ana_t ana;
  psfc_state_t seq_state;
  logic unhealthy, margin_done;
  int err_count, checks_done, n, i;
  // Short timers keep the run small
  psfc_top #(.TERM_50_CYC(300), .POFF_1P5_CYC(10),
    .POFF_12P5_CYC(20), .POFF_25_CYC(30), .POFF_50_CYC(40)) dut (.clock(clock), .reset(reset),
    .cfg(cfg), .cmd(cmd), .mrg(mrg), .chan_enable(chan_enable), .duty_req(duty_req), .out_good(out_good),
    .out_over(out_over), .batt_low_raw(batt_low_raw), .chan_on(chan_on), .ana(ana), .duty(duty),
    .seq_state(seq_state), .seq_pos(seq_pos), .unhealthy(unhealthy), .margin_done(margin_done));
  psfc_analog_model analog (.clock(clock), .reset(reset), .chan_on(chan_on), .stuck_low(stuck_low),
    .over_inj(over_inj), .out_good(out_good), .out_over(out_over));
  // Clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // One-cycle command strobe: power_on, power_off, force_off, margin, margin_sel
  task send(input logic [11:0] c);
    @(posedge clock);
    cmd <= psfc_cmd_t'(c);
    @(posedge clock);
    cmd <= '0;
  endtask : send
  // Bounded wait: 0 state, 1 channel mask, 2 margin done; n counts cycles
  task wt(input int k, input logic [3:0] v);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!(k == 0 ? seq_state === psfc_state_t'(v[2:0]) : k == 1 ? chan_on === v : margin_done === 1'b1)
      && n < 6000);
    if (n >= 6000) begin
      err_count++;
      $display("FAIL %0t wait %h %h", $time, k, v);
      results;
    end
  endtask : wt
  task fin(input string s);
    $display("end of %s, mismatches %0d", s, err_count);
  endtask : fin
  task results;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    err_count = 0;
    checks_done = 0;
    reset = 1'b1;
    cfg = '0;
    cfg.pos = {2'h3, 2'h2, 2'h1, 2'h0};
    cmd = '0;
    mrg = '0;
    chan_enable = 4'h0;
    duty_req = '0;
    batt_low_raw = 2'h0;
    stuck_low = 4'h0;
    over_inj = 4'h0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    #1;
    `CHK({chan_on, seq_pos, unhealthy}, 7'h00)
    `CHK(seq_state, ST_IDLE)
    `CHK(duty, {4{8'h1A}})
    fin("reset");
    @(posedge clock);
    duty_req <= {8'h19, 8'h1A, 8'hE6, 8'hE7};
    repeat (2) @(posedge clock);
    #1;
    `CHK(duty, {8'h1A, 8'h1A, 8'hE6, 8'hE6})
    fin("duty");
    send(12'h800);
    for (i = 1; i < 16; i = i * 2 + 1) wt(1, 4'(i));
    wt(0, {1'b0, ST_ON});
    send(12'h400);
    #1;
    `CHK({seq_state, seq_pos}, {ST_POFF_WAIT, LAST_POS})
    wt(1, 4'h7);
    for (i = 3; i > 0; i--) begin
      wt(1, 4'((1 << i) - 2 >> 1));
      `CHK(n > 10, 1'b1)
    end
    wt(0, {1'b0, ST_IDLE});
    fin("sequencing");
    send(12'h800);
    send(12'h200);
    #1;
    `CHK(seq_state, ST_IDLE)
    repeat (3) @(posedge clock);
    #1;
    `CHK(chan_on, 4'h0)
    cfg.term_sel <= TERM_50;
    stuck_low <= 4'h4;
    send(12'h800);
    wt(1, 4'h7);
    wt(1, 4'h0);
    `CHK(n >= 295 && n <= 306, 1'b1)
    `CHK(seq_state, ST_IDLE)
    stuck_low <= 4'h0;
    cfg.term_sel <= TERM_OFF;
    fin("termination");
    cfg.manual <= 4'h8;
    cfg.fault_act <= ACT_FORCE;
    cfg.health_en <= 1'b1;
    cfg.glitch_on <= 4'hF;
    chan_enable <= 4'h8;
    wt(1, 4'h8);
    chan_enable <= 4'h0;
    wt(1, 4'h0);
    chan_enable <= 4'h8;
    send(12'h800);
    wt(0, {1'b0, ST_ON});
    `CHK(chan_on, 4'hF)
    over_inj <= 4'h2;
    wt(0, {1'b0, ST_IDLE});
    `CHK(n > 400, 1'b1)
    repeat (4) @(posedge clock);
    #1;
    `CHK({chan_on, unhealthy}, 5'h11)
    over_inj <= 4'h0;
    fin("fault");
    cfg.manual <= 4'h0;
    chan_enable <= 4'h0;
    cfg.batt_act <= ACT_FORCE;
    cfg.batt_latch <= 1'b1;
    send(12'h800);
    wt(0, {1'b0, ST_ON});
    `CHK(unhealthy, 1'b0)
    batt_low_raw <= 2'h2;
    wt(1, 4'h0);
    batt_low_raw <= 2'h0;
    repeat (20) @(posedge clock);
    #1;
    `CHK(seq_state, ST_IDLE)
    send(12'h800);
    wt(0, {1'b0, ST_ON});
    cfg.batt_latch <= 1'b0;
    cfg.batt_act <= ACT_POFF;
    batt_low_raw <= 2'h1;
    wt(1, 4'h7);
    wt(1, 4'h0);
    batt_low_raw <= 2'h0;
    wt(1, 4'hF);
    fin("battery");
    mrg.nom <= {4{8'h04}};
    mrg.high <= {4{8'h06}};
    mrg.low <= {4{8'h02}};
    cfg.tap <= {3'h5, 3'h2};
    cfg.slew_sel <= 3'h6;
    cfg.slew_dis <= 4'h9;
    cfg.mon_level <= 8'hE4;
    send({4'b0001, 2'b11, 2'b00, 2'b10, 2'b01});
    #1;
    `CHK(margin_done, 1'b0)
    wt(2, 4'h0);
    `CHK(ana.vset, {8'h04, 8'h04, 8'h02, 8'h06})
    `CHK({ana.tap, ana.slew_sel, ana.slew_en, ana.mon_level}, {3'h5, 3'h2, 3'h6, 4'h6, 8'hE4})
    fin("margin");
    results;
  end
endmodule : power_sequencer_fault_control_bench
